// ---- logic/ppp_dev.sv ----
/*
 * ppp_dev: device end of the parallel programming port, with small flash,
 * eeprom, fuse and lock storage in flip-flops.
 * Assumes pins come asynchronously from the programmer and are synchronised here.
 */
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - action 10 loads command byte
// - action 00 loads low/high address byte
// - action 01 loads low/high data byte
// - page latch stores data word into buffer
// - low bits word, high bits page
// - write strobe programs page, busy low
// - command 00 clears write controls
// - programmer repeats load sequence per page
// - eeprom page write with byte select low
// - flash read drives low/high byte
// - eeprom read drives addressed byte
// - fuse bits zero program, one erase
// - byte selects pick fuse target
// - lock write programs zero bits
// - lock mode 3 blocks boot locks
// - lock bits never cleared here
// - fuse/lock read by byte selects
// - signature byte by low address
// - calibration byte by high byte select
// - drive bus only while enable low
// - ready/busy low during programming
// - command and address kept
module ppp_dev (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    ppp_if.dev PINS
);
    localparam int FW = 1 << ppp_pkg::FLASH_WORD_BITS; // words per flash page
    localparam int FN = 1 << ppp_pkg::FLASH_ADDR_BITS; // flash words
    localparam int EW = 1 << ppp_pkg::EEP_WORD_BITS;
    localparam int EN = 1 << ppp_pkg::EEP_ADDR_BITS;

    // two-stage synchronisers, first stage read only by second
    logic [14:0] s1_r, s2_r;
    logic ld_d_r, pl_d_r, wr_d_r; // delayed copies for edge detect
    wire [14:0] raw = {PINS.action_sel, PINS.byte_select_high, PINS.byte_select_extended,
        PINS.page_latch_strobe, PINS.load_strobe_pin, PINS.wr_n, PINS.data_bus};
    wire [1:0] act = s2_r[14:13];
    wire bs1 = s2_r[12];
    wire bs2 = s2_r[11];
    wire pl = s2_r[10];
    wire ld = s2_r[9];
    wire wrn = s2_r[8];
    wire [7:0] din = s2_r[7:0];
    // oe is its own two-flop chain so the bus turns around cleanly
    logic oe_s1_r, oe_s2_r;

    // edge strobes, one cycle each
    wire ld_rise = ld & ~ld_d_r;
    wire pl_rise = pl & ~pl_d_r;
    wire wr_fall = ~wrn & wr_d_r;

    // loaded state
    logic [7:0] cmd_r, alo_r, ahi_r, dlo_r, dhi_r;
    logic [7:0] fuse_lo_r, fuse_hi_r, fuse_ex_r, lock_r;
    logic [7:0] busy_cnt_r;
    logic wr_arm_r; // internal write control
    logic [15:0] fbuf_r [FW]; // flash page buffer
    logic [15:0] flash_r [FN];
    logic [7:0] ebuf_r [EW];
    logic [EW-1:0] ebuf_v_r; // only loaded eeprom bytes are altered
    logic [FW-1:0] fbuf_v_r;
    logic [7:0] eep_r [EN];
    logic [7:0] dout_r;
    logic doe_r, rdy_r;

    wire busy = busy_cnt_r != 8'h00;
    wire [15:0] addr = {ahi_r, alo_r};
    // word within page and page index split
    wire [ppp_pkg::FLASH_WORD_BITS-1:0] fword = alo_r[ppp_pkg::FLASH_WORD_BITS-1:0];
    wire [ppp_pkg::FLASH_ADDR_BITS-1:0] fpage_base =
        {addr[ppp_pkg::FLASH_ADDR_BITS-1:ppp_pkg::FLASH_WORD_BITS],
        ppp_pkg::FLASH_WORD_BITS'(0)};
    wire [ppp_pkg::EEP_WORD_BITS-1:0] eword = alo_r[ppp_pkg::EEP_WORD_BITS-1:0];
    wire [ppp_pkg::EEP_ADDR_BITS-1:0] epage_base =
        {alo_r[ppp_pkg::EEP_ADDR_BITS-1:ppp_pkg::EEP_WORD_BITS], ppp_pkg::EEP_WORD_BITS'(0)};
    wire [15:0] frd = flash_r[addr[ppp_pkg::FLASH_ADDR_BITS-1:0]];
    // lock mode 3: both main lock bits programmed
    wire lock_m3 = ~lock_r[0] & ~lock_r[1];
    // boot lock bits only programmable (zeroed) when not in mode 3; never cleared
    wire [7:0] lock_nxt = lock_r & (lock_m3 ? {4'hF, dlo_r[3:0]} : dlo_r);

    // read mux by command and selects
    logic [7:0] rd_nxt;
    always_comb begin
        rd_nxt = 8'hFF;
        case (cmd_r)
            ppp_pkg::CMD_RD_FLASH: rd_nxt = bs1 ? frd[15:8] : frd[7:0];
            ppp_pkg::CMD_RD_EEP: rd_nxt = eep_r[alo_r];
            ppp_pkg::CMD_RD_FUSE: begin
                case ({bs2, bs1})
                    2'h0: rd_nxt = fuse_lo_r;
                    2'h3: rd_nxt = fuse_hi_r;
                    2'h2: rd_nxt = fuse_ex_r;
                    default: rd_nxt = lock_r;
                endcase
            end
            ppp_pkg::CMD_RD_SIG: begin
                if (bs1) begin
                    rd_nxt = ppp_pkg::CAL_BYTE;
                end else if (alo_r == 8'h00) begin
                    rd_nxt = ppp_pkg::SIG0;
                end else if (alo_r == 8'h01) begin
                    rd_nxt = ppp_pkg::SIG1;
                end else if (alo_r == 8'h02) begin
                    rd_nxt = ppp_pkg::SIG2;
                end
            end
            default: rd_nxt = 8'hFF;
        endcase
    end

    // synchronisers and edge history
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            // idle pin levels, so no false strobe edge follows reset
            s1_r <= 15'h6100;
            s2_r <= 15'h6100;
            oe_s1_r <= 1'b1;
            oe_s2_r <= 1'b1;
            ld_d_r <= 1'b0;
            pl_d_r <= 1'b0;
            wr_d_r <= 1'b1;
        end else if (CE) begin
            s1_r <= raw;
            s2_r <= s1_r;
            oe_s1_r <= PINS.oe_n;
            oe_s2_r <= oe_s1_r;
            ld_d_r <= ld;
            pl_d_r <= pl;
            wr_d_r <= wrn;
        end
    end

    // command, address and data loading, kept until reloaded
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cmd_r <= ppp_pkg::CMD_NOP;
            alo_r <= 8'h00;
            ahi_r <= 8'h00;
            dlo_r <= 8'hFF;
            dhi_r <= 8'hFF;
        end else if (CE && ld_rise && !busy) begin
            case (act)
                ppp_pkg::ACT_CMD: if (!bs1) cmd_r <= din;
                ppp_pkg::ACT_ADDR: if (bs1) ahi_r <= din; else alo_r <= din;
                ppp_pkg::ACT_DATA: if (bs1) dhi_r <= din; else dlo_r <= din;
                default: ; // idle action
            endcase
        end
    end

    // page buffers, programming and self-timed busy
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_arm_r <= 1'b0;
            fbuf_v_r <= '0;
            ebuf_v_r <= '0;
            busy_cnt_r <= 8'h00;
            fuse_lo_r <= ppp_pkg::FUSE_LO_RST;
            fuse_hi_r <= ppp_pkg::FUSE_HI_RST;
            fuse_ex_r <= ppp_pkg::FUSE_EX_RST;
            lock_r <= ppp_pkg::LOCK_RST;
            for (int i = 0; i < FW; i++) fbuf_r[i] <= 16'hFFFF;
            for (int i = 0; i < EW; i++) ebuf_r[i] <= 8'hFF;
            for (int i = 0; i < FN; i++) flash_r[i] <= 16'hFFFF;
            for (int i = 0; i < EN; i++) eep_r[i] <= 8'hFF;
        end else if (CE) begin
            if (busy) begin
                busy_cnt_r <= busy_cnt_r - 8'h01;
            end
            if (ld_rise && !busy && act == ppp_pkg::ACT_CMD && !bs1) begin
                wr_arm_r <= din != ppp_pkg::CMD_NOP;
                if (din == ppp_pkg::CMD_NOP) begin
                    fbuf_v_r <= '0;
                    ebuf_v_r <= '0;
                end
            end
            if (pl_rise && !busy) begin
                if (cmd_r == ppp_pkg::CMD_WR_FLASH && bs1) begin
                    fbuf_r[fword] <= {dhi_r, dlo_r};
                    fbuf_v_r[fword] <= 1'b1;
                end else if (cmd_r == ppp_pkg::CMD_WR_EEP) begin
                    ebuf_r[eword] <= dlo_r;
                    ebuf_v_r[eword] <= 1'b1;
                end
            end
            if (wr_fall && !busy && wr_arm_r) begin
                busy_cnt_r <= ppp_pkg::WRITE_CYCLES;
                case (cmd_r)
                    ppp_pkg::CMD_WR_FLASH: begin
                        for (int i = 0; i < FW; i++) begin
                            if (fbuf_v_r[i]) flash_r[fpage_base + 8'(i)] <= fbuf_r[i];
                        end
                        fbuf_v_r <= '0;
                    end
                    ppp_pkg::CMD_WR_EEP: begin
                        if (!bs1) begin
                            for (int i = 0; i < EW; i++) begin
                                if (ebuf_v_r[i]) eep_r[epage_base + 8'(i)] <= ebuf_r[i];
                            end
                            ebuf_v_r <= '0;
                        end
                    end
                    ppp_pkg::CMD_WR_FUSE: begin
                        if (!bs1 && !bs2) fuse_lo_r <= dlo_r;
                        else if (bs1 && !bs2) fuse_hi_r <= dlo_r;
                        else if (!bs1 && bs2) fuse_ex_r <= dlo_r;
                    end
                    ppp_pkg::CMD_WR_LOCK: lock_r <= lock_nxt;
                    default: ;
                endcase
            end
        end
    end

    // output pins: bus driven only while enable low
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            dout_r <= 8'h00;
            doe_r <= 1'b0;
            rdy_r <= 1'b1;
        end else if (CE) begin
            dout_r <= rd_nxt;
            doe_r <= ~oe_s2_r & ~PINS.oe_n; // drop on the first clock edge after release, avoids contention
            rdy_r <= ~busy & ~(wr_fall & wr_arm_r);
        end
    end
    assign PINS.data_dev_o = dout_r;
    assign PINS.data_dev_oe = doe_r;
    assign PINS.ready_busy_out = rdy_r;
endmodule
`default_nettype wire

// ---- logic/ppp_pkg.sv ----
/*
 * ppp_pkg: shared constants for the parallel programming port.
 * Assumes a single 100 MHz clock on both ends; no imports anywhere.
 */
`default_nettype none
package ppp_pkg;
    // action select codes
    localparam logic [1:0] ACT_ADDR = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_CMD = 2'h2;
    localparam logic [1:0] ACT_IDLE = 2'h3;
    // command bytes
    localparam logic [7:0] CMD_NOP = 8'h00;
    localparam logic [7:0] CMD_WR_FLASH = 8'h10;
    localparam logic [7:0] CMD_WR_EEP = 8'h11;
    localparam logic [7:0] CMD_RD_SIG = 8'h08;
    localparam logic [7:0] CMD_RD_FUSE = 8'h04;
    localparam logic [7:0] CMD_RD_FLASH = 8'h02;
    localparam logic [7:0] CMD_RD_EEP = 8'h03;
    localparam logic [7:0] CMD_WR_FUSE = 8'h40;
    localparam logic [7:0] CMD_WR_LOCK = 8'h20;
    // memory geometry: word-in-page bits and whole word-address bits
    localparam int FLASH_WORD_BITS = 5;
    localparam int FLASH_ADDR_BITS = 8;
    localparam int EEP_WORD_BITS = 2;
    localparam int EEP_ADDR_BITS = 8;
    // reset values of fuses, lock and a neutral identity (arbitrary values)
    localparam logic [7:0] FUSE_LO_RST = 8'hFF;
    localparam logic [7:0] FUSE_HI_RST = 8'hFF;
    localparam logic [7:0] FUSE_EX_RST = 8'hFF;
    localparam logic [7:0] LOCK_RST = 8'hFF;
    localparam logic [7:0] SIG0 = 8'h5A; // arbitrary value
    localparam logic [7:0] SIG1 = 8'h01; // arbitrary value
    localparam logic [7:0] SIG2 = 8'h02; // arbitrary value
    localparam logic [7:0] CAL_BYTE = 8'h80; // arbitrary value
    // self-timed write length
    localparam int WRITE_TIME_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam logic [7:0] WRITE_CYCLES = 8'(WRITE_TIME_NS / CLK_PERIOD_NS);
    // programmer strobe width
    localparam int PULSE_NS = 250;
    localparam logic [7:0] PULSE_CYCLES = 8'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
endpackage
`default_nettype wire

// ---- logic/ppp_if.sv ----
/*
 * ppp_if: programming pins between programmer and device.
 * Resolves the data bus here from the device enable alone.
 */
`timescale 1ns/1ps
`default_nettype none
interface ppp_if;
    logic [1:0] action_sel; // action_select_hi/lo
    logic byte_select_high;
    logic byte_select_extended;
    logic page_latch_strobe;
    logic load_strobe_pin;
    logic wr_n; // write strobe, active low
    logic oe_n; // output enable, active low
    logic ready_busy_out;
    logic [7:0] data_host_o; // programmer drive
    logic data_host_oe;
    logic [7:0] data_dev_o; // device drive
    logic data_dev_oe;
    wire [7:0] data_bus = data_dev_oe ? data_dev_o : data_host_o; // resolved level
    modport dev (input action_sel, byte_select_high, byte_select_extended, page_latch_strobe,
        load_strobe_pin, wr_n, oe_n, data_bus, output ready_busy_out, data_dev_o, data_dev_oe);
    modport host (output action_sel, byte_select_high, byte_select_extended,
        page_latch_strobe, load_strobe_pin, wr_n, oe_n, data_host_o, data_host_oe,
        input ready_busy_out, data_bus);
endinterface
`default_nettype wire

// ---- logic/ppp_host.sv ----
/*
 * ppp_host: programmer end. Takes one pin-level order at a time from a user
 * port and plays it out as a strobed sequence on the programming pins.
 * Assumes the device end synchronises strobes; widths come from the package.
 */
`timescale 1ns/1ps
`default_nettype none
module ppp_host (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic CE,
    input wire logic REQ, // one-cycle order pulse
    input wire logic [2:0] OP, // 0 load,1 latch,2 write,3 read
    input wire logic [1:0] ACT, // action select for loads
    input wire logic BS1,
    input wire logic BS2,
    input wire logic [7:0] DATA,
    output logic DONE,
    output logic [7:0] RDATA,
    output logic READY,
    ppp_if.host PINS
);
    typedef enum logic [1:0] {
        PH_IDLE = 2'b00,
        PH_SET = 2'b01,
        PH_PULSE = 2'b10,
        PH_WAIT = 2'b11
    } ppp_ph_e;
    ppp_ph_e st_r;
    logic [2:0] op_r;
    logic [7:0] cnt_r, rd_r;
    logic [1:0] act_r;
    logic bs1_r, bs2_r, ld_r, pl_r, wrn_r, oen_r, doe_r, done_r;
    logic [7:0] dat_r;
    logic rb1_r, rb2_r; // ready/busy synchroniser
    wire cnt_end = cnt_r == 8'h00;

    // ready/busy passes two flops
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rb1_r <= 1'b0;
            rb2_r <= 1'b0;
        end else if (CE) begin
            rb1_r <= PINS.ready_busy_out;
            rb2_r <= rb1_r;
        end
    end

    // sequencer: set levels, pulse for the minimum width, then settle
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            st_r <= PH_IDLE;
            op_r <= 3'h0;
            cnt_r <= 8'h00;
            act_r <= ppp_pkg::ACT_IDLE;
            bs1_r <= 1'b0;
            bs2_r <= 1'b0;
            ld_r <= 1'b0;
            pl_r <= 1'b0;
            wrn_r <= 1'b1;
            oen_r <= 1'b1;
            doe_r <= 1'b0;
            dat_r <= 8'h00;
            rd_r <= 8'h00;
            done_r <= 1'b0;
        end else if (CE) begin
            done_r <= 1'b0;
            case (st_r)
                PH_IDLE: if (REQ) begin
                    op_r <= OP;
                    act_r <= ACT;
                    bs1_r <= BS1;
                    bs2_r <= BS2;
                    dat_r <= DATA;
                    doe_r <= OP == 3'h0; // drive bus only for loads
                    cnt_r <= ppp_pkg::PULSE_CYCLES;
                    st_r <= PH_SET;
                end
                PH_SET: if (cnt_end) begin
                    ld_r <= op_r == 3'h0;
                    pl_r <= op_r == 3'h1;
                    wrn_r <= op_r != 3'h2;
                    oen_r <= op_r != 3'h3;
                    cnt_r <= ppp_pkg::PULSE_CYCLES;
                    st_r <= PH_PULSE;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
                PH_PULSE: if (cnt_end) begin
                    if (!oen_r) rd_r <= PINS.data_bus; // held long past sync delay
                    ld_r <= 1'b0;
                    pl_r <= 1'b0;
                    wrn_r <= 1'b1;
                    oen_r <= 1'b1;
                    cnt_r <= ppp_pkg::PULSE_CYCLES;
                    st_r <= PH_WAIT;
                end else begin
                    cnt_r <= cnt_r - 8'h01;
                end
                PH_WAIT: if (cnt_end && rb2_r) begin // wait out busy
                    doe_r <= 1'b0;
                    done_r <= 1'b1;
                    st_r <= PH_IDLE;
                end else if (!cnt_end) begin
                    cnt_r <= cnt_r - 8'h01;
                end
                default: st_r <= PH_IDLE;
            endcase
        end
    end

    assign PINS.action_sel = act_r;
    assign PINS.byte_select_high = bs1_r;
    assign PINS.byte_select_extended = bs2_r;
    assign PINS.load_strobe_pin = ld_r;
    assign PINS.page_latch_strobe = pl_r;
    assign PINS.wr_n = wrn_r;
    assign PINS.oe_n = oen_r;
    assign PINS.data_host_o = dat_r;
    assign PINS.data_host_oe = doe_r;
    assign DONE = done_r;
    assign RDATA = rd_r;
    assign READY = rb2_r;
endmodule
`default_nettype wire

// ---- tb/ppp_asserts.sv ----
/* ppp_asserts: pin-level checks between the programmer end and the device end.
 * Assumes one clock domain; inputs are the ppp_if signals, connected by name. */
`timescale 1ns/1ps
`default_nettype none
module ppp_asserts (
    input wire logic CLK,
    input wire logic RESET_N,
    input wire logic [1:0] action_sel,
    input wire logic byte_select_high,
    input wire logic byte_select_extended,
    input wire logic load_strobe_pin,
    input wire logic wr_n,
    input wire logic oe_n,
    input wire logic ready_busy_out,
    input wire logic [7:0] data_host_o,
    input wire logic data_host_oe,
    input wire logic data_dev_oe,
    input wire logic [7:0] data_bus
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESET_N);
    logic ld_q_r; // load strobe one cycle ago
    logic wr_q_r; // write strobe one cycle ago
    logic [7:0] cmd_r; // shadow of the last loaded command
    logic [7:0] since_wr_r; // age of last write strobe, saturating
    // command loads seen on the pins
    wire cmd_ld = load_strobe_pin && !ld_q_r && action_sel == ppp_pkg::ACT_CMD &&
        !byte_select_high;
    // commands that start a self-timed write
    wire wr_cmd = cmd_r inside {ppp_pkg::CMD_WR_FLASH, ppp_pkg::CMD_WR_EEP,
        ppp_pkg::CMD_WR_FUSE, ppp_pkg::CMD_WR_LOCK};
    // saturating age keeps busy tied to a recent strobe, not any strobe
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ld_q_r <= 1'b0;
            wr_q_r <= 1'b1;
            cmd_r <= ppp_pkg::CMD_NOP;
            since_wr_r <= 8'hFF;
        end else begin
            ld_q_r <= load_strobe_pin;
            wr_q_r <= wr_n;
            cmd_r <= cmd_ld ? data_bus : cmd_r;
            since_wr_r <= (wr_q_r && !wr_n) ? 8'h00 :
                (since_wr_r == 8'hFF ? since_wr_r : since_wr_r + 8'h01);
        end
    end
    dev_drive_a: assert property (data_dev_oe |-> !oe_n || !$past(oe_n))
        else $error("device drives bus with output enable high");
    oe_follow_a: assert property (!oe_n [*8] |-> data_dev_oe)
        else $error("device silent while output enable low");
    host_release_a: assert property (!oe_n |-> !data_host_oe)
        else $error("programmer drives bus during a read");
    busy_start_a: assert property ($fell(wr_n) && wr_cmd && ready_busy_out &&
        !(byte_select_high && byte_select_extended) |-> ##[1:8] !ready_busy_out)
        else $error("write strobe did not start busy");
    busy_len_a: assert property ($fell(ready_busy_out) |=>
        !ready_busy_out [*8] ##[80:100] ready_busy_out)
        else $error("busy period has wrong length");
    busy_cause_a: assert property ($fell(ready_busy_out) |-> since_wr_r < 8'h08)
        else $error("busy without a write strobe");
    nop_idle_a: assert property ($fell(wr_n) && cmd_r == ppp_pkg::CMD_NOP &&
        ready_busy_out |=> ready_busy_out [*8])
        else $error("write strobe acted under no-operation");
    load_hold_a: assert property (load_strobe_pin |-> $stable(action_sel) &&
        $stable(data_host_o) && $stable(byte_select_high))
        else $error("load qualifiers moved during load strobe");
    wr_ready_a: assert property ($fell(wr_n) |-> ready_busy_out)
        else $error("write strobe while device busy");
    cover property ($fell(ready_busy_out) && cmd_r == ppp_pkg::CMD_WR_FLASH);
    cover property ($fell(ready_busy_out) && cmd_r == ppp_pkg::CMD_WR_LOCK);
    cover property (data_dev_oe && byte_select_high);
endmodule
`default_nettype wire

// ---- tb/tb_top.sv ----
/* tb_top: drives the programmer end's order port, reads memories back.
 * Assumes one 100 MHz clock for both ends, joined by ppp_if. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk; // 100 MHz
    logic rst_n; // active-low reset
    logic req; // one-cycle order pulse
    logic [2:0] op; // order kind
    logic [1:0] act; // action select of a load
    logic bs1; // high byte select
    logic bs2; // extended byte select
    logic [7:0] din; // byte to load
    logic done; // order finished
    logic [7:0] rdata; // byte of last read
    logic ready; // synced ready/busy
    logic [7:0] d [4]; // random payload
    logic [7:0] lk; // expected lock byte
    logic [7:0] fa [3] = '{8'h60, 8'h7F, 8'h61}; // first, last, unlatched word
    logic [1:0] wsel [3] = '{2'b00, 2'b01, 2'b10}; // {bs2,bs1} fuse write
    logic [1:0] rsel [3] = '{2'b00, 2'b11, 2'b10}; // {bs2,bs1} fuse read
    logic [7:0] lv [4] = '{8'hF7, 8'hFC, 8'h0F, 8'hFF}; // lock writes, mode 3 on 2nd
    logic [7:0] sg [3] = '{ppp_pkg::SIG0, ppp_pkg::SIG1, ppp_pkg::SIG2};
    int error_cnt;
    int n_compared;
    ppp_if pins_i ();
    ppp_dev ppp_dev_i (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .PINS(pins_i));
    ppp_host ppp_host_i (.CLK(clk), .RESET_N(rst_n), .CE(1'b1), .REQ(req), .OP(op),
        .ACT(act), .BS1(bs1), .BS2(bs2), .DATA(din), .DONE(done), .RDATA(rdata),
        .READY(ready), .PINS(pins_i));
    ppp_asserts ppp_asserts_i (.CLK(clk), .RESET_N(rst_n), .action_sel(pins_i.action_sel),
        .byte_select_high(pins_i.byte_select_high),
        .byte_select_extended(pins_i.byte_select_extended),
        .load_strobe_pin(pins_i.load_strobe_pin), .wr_n(pins_i.wr_n), .oe_n(pins_i.oe_n),
        .ready_busy_out(pins_i.ready_busy_out), .data_host_o(pins_i.data_host_o),
        .data_host_oe(pins_i.data_host_oe), .data_dev_oe(pins_i.data_dev_oe),
        .data_bus(pins_i.data_bus));
    // free-running clock
    always #5 clk = ~clk;
    // lock bits only fall; boot bits freeze once both main bits are 0
    function automatic logic [7:0] lock_next(input logic [7:0] old, input logic [7:0] v);
        logic [7:0] keep;
        keep = (old[1:0] == 2'b00) ? 8'hF0 : 8'h00;
        return old & (v | keep);
    endfunction
    task automatic conclude();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one order on the user port, then a bounded wait for completion
    task automatic order(input logic [2:0] o, input logic [1:0] a, input logic b1,
            input logic b2, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clk);
        req <= 1'b1;
        op <= o;
        act <= a;
        bs1 <= b1;
        bs2 <= b2;
        din <= v;
        @(posedge clk);
        req <= 1'b0;
        #1;
        while (done !== 1'b1) begin
            n++;
            if (n > 2000) begin
                error_cnt++;
                conclude();
            end
            @(posedge clk);
            #1;
        end
    endtask
    task automatic ld(input logic [1:0] a, input logic b1, input logic [7:0] v);
        order(3'h0, a, b1, 1'b0, v);
    endtask
    // latch always with high select up, as the page latch asks
    task automatic latch();
        order(3'h1, ppp_pkg::ACT_IDLE, 1'b1, 1'b0, 8'h00);
    endtask
    // write strobe, then wait for ready before anything else
    task automatic wr(input logic b1, input logic b2);
        int n;
        n = 0;
        order(3'h2, ppp_pkg::ACT_IDLE, b1, b2, 8'h00);
        while (ready !== 1'b1) begin
            n++;
            if (n > 400) begin
                error_cnt++;
                conclude();
            end
            @(posedge clk);
            #1;
        end
    endtask
    task automatic rd(input string nm, input logic b1, input logic b2, input logic [7:0] e);
        order(3'h3, ppp_pkg::ACT_IDLE, b1, b2, 8'h00);
        chk(nm, rdata, e);
    endtask
    // main sequence
    initial begin
        clk = 1'b0;
        rst_n = 1'b0;
        req = 1'b0;
        op = 3'h0;
        act = ppp_pkg::ACT_IDLE;
        bs1 = 1'b0;
        bs2 = 1'b0;
        din = 8'h00;
        error_cnt = 0;
        n_compared = 0;
        void'($urandom(43));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("ready at reset", {7'h00, pins_i.ready_busy_out}, 8'h01);
        chk("bus idle at reset", {7'h00, pins_i.data_dev_oe}, 8'h00);
        repeat (3) @(posedge clk);
        // flash: first and last word of page 3, word 1 left unlatched
        foreach (d[i]) d[i] = 8'($urandom);
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FLASH);
        for (int i = 0; i < 2; i++) begin
            ld(ppp_pkg::ACT_ADDR, 1'b0, fa[i]);
            ld(ppp_pkg::ACT_DATA, 1'b0, d[2*i]);
            ld(ppp_pkg::ACT_DATA, 1'b1, d[2*i+1]);
            latch();
        end
        ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
        wr(1'b1, 1'b0);
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_NOP);
        wr(1'b0, 1'b0);
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FLASH);
        for (int i = 0; i < 3; i++) begin
            ld(ppp_pkg::ACT_ADDR, 1'b0, fa[i]);
            rd("flash lo", 1'b0, 1'b0, i < 2 ? d[2*i] : 8'hFF);
            rd("flash hi", 1'b1, 1'b0, i < 2 ? d[2*i+1] : 8'hFF);
        end
        // eeprom page at 0x24, byte 2 left unlatched
        foreach (d[i]) d[i] = 8'($urandom);
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_EEP);
        ld(ppp_pkg::ACT_ADDR, 1'b1, 8'h00);
        for (int i = 0; i < 4; i++) begin
            if (i != 2) begin
                ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h24 + 8'(i));
                ld(ppp_pkg::ACT_DATA, 1'b0, d[i]);
                latch();
            end
        end
        wr(1'b0, 1'b0);
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_EEP);
        for (int i = 0; i < 4; i++) begin
            ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h24 + 8'(i));
            rd("eeprom", 1'b0, 1'b0, i == 2 ? 8'hFF : d[i]);
        end
        // fuses: each target written with its own random byte
        for (int k = 0; k < 3; k++) begin
            d[k] = 8'($urandom);
            ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_FUSE);
            ld(ppp_pkg::ACT_DATA, 1'b0, d[k]);
            wr(wsel[k][0], wsel[k][1]);
        end
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
        for (int k = 0; k < 3; k++) begin
            rd("fuse", rsel[k][0], rsel[k][1], d[k]);
        end
        // lock: program, enter mode 3, try boot bits, try to clear
        lk = ppp_pkg::LOCK_RST;
        for (int k = 0; k < 4; k++) begin
            ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_WR_LOCK);
            ld(ppp_pkg::ACT_DATA, 1'b0, lv[k]);
            wr(1'b0, 1'b0);
            lk = lock_next(lk, lv[k]);
            ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_FUSE);
            rd("lock", 1'b1, 1'b0, lk);
        end
        // signature bytes and calibration byte
        ld(ppp_pkg::ACT_CMD, 1'b0, ppp_pkg::CMD_RD_SIG);
        for (int k = 0; k < 3; k++) begin
            ld(ppp_pkg::ACT_ADDR, 1'b0, 8'(k));
            rd("signature", 1'b0, 1'b0, sg[k]);
        end
        ld(ppp_pkg::ACT_ADDR, 1'b0, 8'h00);
        rd("calibration", 1'b1, 1'b0, ppp_pkg::CAL_BYTE);
        conclude();
    end
endmodule
`default_nettype wire
